// ==== dv/pll_ratio_function_config_tb_top.sv ====
/* top bench: host model drives the bank; checks readback and cfg_o */
`timescale 1ns/10ps
module pll_ratio_function_config_tb_top;
  import prfc_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic lock = 1'b0;
  logic clk_ok = 1'b0;
  prfc_reg_req_s req;
  prfc_cfg_s cfg;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] rb;
  logic rv;
  logic auto_sw = 1'b0;
  logic auto_dyn = 1'b0;
  // 12.20 example for ratio 0, 20.12 example for ratio 1
  logic [63:0] rpair = {32'h0013a92a, 32'h2df5e208};
  int n_mismatch = 0;
  int n_checks = 0;
  // rows: address, write data, readback
  logic [23:0] rows [4] = '{24'h170000, 24'h17ff18, 24'h1eff70, 24'h1fff00};
  always #25 clock_i = ~clock_i;
  prfc_config_bank u_dut (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .pll_locked_i(lock),
    .input_clk_present_i(clk_ok), .auto_switch_en_i(auto_sw),
    .auto_dynamic_i(auto_dyn), .cfg_o(cfg));
  prfc_host_model u_host (.clock_i(clock_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .req_o(req));
  // ==========
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // write, then let cfg_o settle
  task automatic wr(input logic [7:0] a, d);
    u_host.put(1'b1, a, d, rb, rv);
    repeat (2) @(posedge clock_i);
    #1;
  endtask : wr
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      u_host.put(1'b0, rows[i][23:16], 8'h00, rb, rv);
      chk(rb, rows[i][7:0]);
      chk(rv, 1'b1);
    end
    $display("table done");
    chk(cfg.clk_out_gate, 1'b1);
    for (int c = 0; c < 4; c++)
    begin
      wr(FUNC_CFG_ONE_ADDR, 8'(c << REF_DIV_LSB));
      chk(cfg.ref_div_factor, c == 1 ? DIV_FACTOR_2 :
          c == 2 ? DIV_FACTOR_1 : DIV_FACTOR_4);
      chk(cfg.ref_div_bad, c == 3);
    end
    wr(FUNC_CFG_TWO_ADDR, 8'h00);
    chk(cfg.clk_out_gate, 1'b0);
    for (int b = 0; b < 8; b++)
      wr(RATIO_BASE_ADDR + 8'(b), 8'(rpair >> (56 - 8 * b)));
    chk(cfg.ratio_value, 32'h0013a92a);
    chk(cfg.ratio_frac_bits, FRAC_BITS_HIGH_RES);
    chk(cfg.dynamic_mode, 1'b0);
    wr(DEV_CFG_TWO_ADDR, 8'h01);
    chk(cfg.ratio_frac_bits, FRAC_BITS_HIGH_MULT);
    chk(cfg.dynamic_mode, 1'b1);
    // auto switching overrides the source bit
    @(posedge clock_i) auto_sw <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk(cfg.dynamic_mode, 1'b0);
    chk(cfg.ratio_frac_bits, FRAC_BITS_HIGH_RES);
    @(posedge clock_i) auto_dyn <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk(cfg.dynamic_mode, 1'b1);
    chk(cfg.ratio_frac_bits, FRAC_BITS_HIGH_MULT);
    @(posedge clock_i) auto_sw <= 1'b0;
    wr(DEV_CFG_TWO_ADDR, 8'h03);
    chk(cfg.ratio_value, 32'h2df5e208);
    wr(FUNC_CFG_TWO_ADDR, 8'h08);
    chk(cfg.ratio_frac_bits, FRAC_BITS_HIGH_RES);
    $display("gate and format done");
    wr(FUNC_CFG_THREE_ADDR, 8'h50);
    wr(GLOBAL_CFG_ADDR, 8'h01);
    @(posedge clock_i) clk_ok <= 1'b1;
    wr(8'h20, 8'h00);
    chk(cfg.active_min_bw, 3'h5);
    @(posedge clock_i) lock <= 1'b1;
    wr(FUNC_CFG_THREE_ADDR, 8'h20);
    chk(cfg.active_min_bw, 3'h5);
    chk(cfg.clk_out_gate, 1'b1);
    @(posedge clock_i) lock <= 1'b0;
    @(posedge clock_i) clk_ok <= 1'b0;
    @(posedge clock_i) clk_ok <= 1'b1;
    wr(8'h20, 8'h00);
    chk(cfg.active_min_bw, 3'h2);
    $display("bandwidth done");
    // mid-run reset returns the bank and cfg_o to rest
    wr(FUNC_CFG_ONE_ADDR, 8'h08);
    wr(FUNC_CFG_TWO_ADDR, 8'h10);
    @(posedge clock_i) rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk(cfg.ref_div_factor, DIV_FACTOR_4);
    chk(cfg.ratio_frac_bits, FRAC_BITS_HIGH_RES);
    chk(cfg.clk_out_gate, 1'b0);
    chk(cfg.active_min_bw, MIN_BW_RST);
    chk(cfg.dynamic_mode, 1'b0);
    @(posedge clock_i) rst_i <= 1'b0;
    u_host.put(1'b0, FUNC_CFG_TWO_ADDR, 8'h00, rb, rv);
    chk(rb, FUNC_CFG_TWO_RST);
    chk(rv, 1'b1);
    chk(cfg.clk_out_gate, 1'b0);
    chk(cfg.active_min_bw, MIN_BW_RST);
    $display("reset done");
    close_out();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule : pll_ratio_function_config_tb_top

// ==== dv/prfc_config_bank_properties.sv ====
/* checker for the config bank; sees only its ports, bound below */
`timescale 1ns/10ps
module prfc_config_bank_properties
  import prfc_pkg::*;
(
  // watched ports
  input wire logic clock_i,
  input wire logic rst_i,
  input prfc_pkg::prfc_reg_req_s req_i,
  input logic [7:0] rdata_o,
  input logic rvalid_o,
  input wire logic pll_locked_i,
  input prfc_pkg::prfc_cfg_s cfg_o
);
  // ==========
  // unlock bit shadow, updated on the same edge as the register
  logic ulk;
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      ulk <= 1'b0;
    else if (req_i.wr_en && req_i.addr == FUNC_CFG_TWO_ADDR)
      ulk <= req_i.wdata[UNLOCK_OE_BIT];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_held;
    pll_locked_i [*4];
  endsequence
  sequence s_rd2;
    req_i.rd_en && req_i.addr == FUNC_CFG_TWO_ADDR;
  endsequence
  a_read_answer: assert property (req_i.rd_en |=> rvalid_o)
    else $error("read not answered");
  a_read_cause: assert property (rvalid_o |-> $past(req_i.rd_en))
    else $error("answer without read");
  a_unmapped_zero: assert property
    (req_i.rd_en && req_i.addr == 8'h1f |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_fc2_reserved: assert property (s_rd2 |=> (rdata_o & 8'he7) == 8'h00)
    else $error("reserved bits set");
  a_fc3_reserved: assert property
    (req_i.rd_en && req_i.addr == FUNC_CFG_THREE_ADDR
     |=> (rdata_o & 8'h8f) == 8'h00)
    else $error("reserved bits set");
  a_static_format: assert property
    (!cfg_o.dynamic_mode |-> cfg_o.ratio_frac_bits == FRAC_BITS_HIGH_RES)
    else $error("static format wrong");
  a_rsvd_div: assert property
    (cfg_o.ref_div_bad |-> cfg_o.ref_div_factor == DIV_FACTOR_4)
    else $error("reserved divider factor");
  a_gate_low: assert property (!ulk && !pll_locked_i |=> !cfg_o.clk_out_gate)
    else $error("output not forced low");
  a_gate_on: assert property (ulk |=> cfg_o.clk_out_gate)
    else $error("output not enabled");
  a_bw_hold: assert property (s_held |-> $stable(cfg_o.active_min_bw))
    else $error("bandwidth moved while locked");
endmodule : prfc_config_bank_properties
bind prfc_config_bank prfc_config_bank_properties u_prop (
  .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .pll_locked_i(pll_locked_i), .cfg_o(cfg_o));

// ==== dv/prfc_host_model.sv ====
/* host model on the register port; assumes the bench clock */
`timescale 1ns/10ps
module prfc_host_model
  import prfc_pkg::*;
(
  // bench side
  input wire logic clock_i,
  input logic [7:0] rdata_i,
  input logic rvalid_i,
  // register port
  output prfc_pkg::prfc_reg_req_s req_o
);
  // ==========
  initial req_o = '0;
  // callers keep reserved bits zero, bar the masking probes
  task automatic put(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q, output logic v);
    @(posedge clock_i);
    req_o <= '{w, !w, a, d};
    @(posedge clock_i);
    // released lines show the inverse, not a stale value
    req_o <= '{1'b0, 1'b0, ~a, ~d};
    @(posedge clock_i);
    q = rdata_i;
    v = rvalid_i;
  endtask : put
endmodule : prfc_host_model

// ==== logic/prfc_config_bank.sv ====
/*
  configuration bank: four user ratios, the device configuration bits
  and function configuration registers 1 to 3, plus the controls that
  the synthesizer core reads from them (divider, output gate, ratio
  format, minimum loop bandwidth, mode and indexed ratio).
  assumes register requests are synchronous to clock_i and one cycle
  long, decoded by the control port in front of this block;
  pll_locked_i and input_clk_present_i come from the analog pll and
  are already synchronous; auto_switch_en_i and auto_dynamic_i come
  from the clock switching logic.
*/
// Function
// RQ1 - ref divider code gives divide 4,2,1
// RQ2 - host matches divider code to reference frequency
// RQ3 - bit 0: outputs low while unlocked
// RQ4 - bit 1: outputs always enabled
// RQ5 - hybrid mode: format bit picks 20.12/12.20
// RQ6 - synthesizer mode: always 12.20, ignore bit
// RQ7 - bandwidth code gives 1 Hz times 2^code
// RQ8 - bandwidth sampled only at lock acquisition start
// RQ9 - host writes bandwidth before enable bits
// RQ10 - host scales 12.20 ratio by 2^20
// RQ11 - host scales 20.12 ratio by 2^12
// RQ12 - register 17h: bit4 unlock oe, bit3 format
// RQ13 - register 1Eh: bits 6..4 bandwidth
// RQ14 - source bit: 0 static, 1 dynamic mode
// RQ15 - ratio is four bytes, msb lowest address
// RQ16 - reserved bits read back as zero
`timescale 1ns/10ps
module prfc_config_bank
  import prfc_pkg::*;
#(
  // number of stored user ratios, four bytes each
  parameter int RATIO_COUNT = 4
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input prfc_pkg::prfc_reg_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // pll status and clock switching controls
  input wire logic pll_locked_i,
  input wire logic input_clk_present_i,
  input wire logic auto_switch_en_i,
  input wire logic auto_dynamic_i,
  // derived configuration
  output prfc_pkg::prfc_cfg_s cfg_o
);
  import prfc_pkg::*;

  // ==========================================================
  // elaboration check
  // the two-bit index and the fixed 06h..15h window serve four ratios
  // only; any other count would alias bytes or leave them unreachable
  if (RATIO_COUNT != 4)
  begin : g_bad_ratio_count
    $error("RATIO_COUNT must be 4");
  end

  localparam int RATIO_BYTES = 4 * RATIO_COUNT;

  // ==========================================================
  // state: registers, lock tracker and registered outputs
  typedef struct packed {
    logic [RATIO_BYTES-1:0][7:0] ratio;
    logic [7:0] dev_cfg_two;
    logic [7:0] global_cfg;
    logic [7:0] func_one;
    logic [7:0] func_two;
    logic [7:0] func_three;
    prfc_lock_e lock_state;
    logic [2:0] active_bw;
    logic [7:0] rdata;
    logic rvalid;
    prfc_cfg_s cfg;
  } prfc_state_s;

  prfc_state_s st;
  prfc_state_s next_st;

  // ==========================================================
  // working signals of the next-state logic
  logic [1:0] idx;
  logic dynamic;
  logic [4:0] byte_sel;
  logic [31:0] ratio_word;
  logic in_ratio;

  always_comb
  begin
    next_st = st;
    next_st.rvalid = 1'b0;
    in_ratio = (req_i.addr >= RATIO_BASE_ADDR) &&
      (req_i.addr <= RATIO_LAST_ADDR);
    byte_sel = 5'(req_i.addr - RATIO_BASE_ADDR);
    // ==========================================================
    // register writes
    if (req_i.wr_en)
    begin
      // ratio bytes: the lowest address of each group is the msb
      if (in_ratio)
        next_st.ratio[byte_sel[3:0]] = req_i.wdata; // RQ15
      case (req_i.addr)
        DEV_CFG_TWO_ADDR: next_st.dev_cfg_two = {4'h0, req_i.wdata[3:0]};
        GLOBAL_CFG_ADDR: next_st.global_cfg = {7'h0, req_i.wdata[0]};
        FUNC_CFG_ONE_ADDR:
          next_st.func_one = {3'h0, req_i.wdata[4:3], 3'h0};
        // unused bits masked so they read back zero
        FUNC_CFG_TWO_ADDR:
          next_st.func_two = {3'h0, req_i.wdata[4:3], 3'h0}; // RQ12 RQ16
        FUNC_CFG_THREE_ADDR:
          next_st.func_three = {1'b0, req_i.wdata[6:4], 4'h0}; // RQ13 RQ16
        // unmapped addresses fall through and the write is dropped
        default: next_st.func_three = next_st.func_three;
      endcase
    end
    // ==========================================================
    // register reads
    // taken from st, so a write in the same cycle reads the old value
    if (req_i.rd_en)
    begin
      next_st.rvalid = 1'b1;
      if (in_ratio)
        next_st.rdata = st.ratio[byte_sel[3:0]];
      else
        case (req_i.addr)
          DEV_CFG_TWO_ADDR: next_st.rdata = st.dev_cfg_two;
          GLOBAL_CFG_ADDR: next_st.rdata = st.global_cfg;
          FUNC_CFG_ONE_ADDR: next_st.rdata = st.func_one;
          FUNC_CFG_TWO_ADDR: next_st.rdata = st.func_two;
          FUNC_CFG_THREE_ADDR: next_st.rdata = st.func_three;
          // unmapped space reads zero
          default: next_st.rdata = 8'h00;
        endcase
    end
    // ==========================================================
    // lock tracking: bandwidth captured only when acquisition starts;
    // a write to 1Eh while locked waits in the register until the next
    // acquisition, so the loop never changes bandwidth mid-lock
    case (st.lock_state)
      // idle: wait for both enable bits and an input clock
      LOCK_IDLE:
        if (st.dev_cfg_two[DEV_CFG_EN_BIT] && st.global_cfg[DEV_CFG_EN_BIT]
            && input_clk_present_i)
        begin
          next_st.active_bw = st.func_three[MIN_BW_LSB +: 3]; // RQ8 RQ7
          next_st.lock_state = LOCK_ACQUIRE;
        end
      // acquire: losing the input clock drops back to idle
      LOCK_ACQUIRE:
        if (!input_clk_present_i)
          next_st.lock_state = LOCK_IDLE;
        else if (pll_locked_i)
          next_st.lock_state = LOCK_HELD;
      // held: left only on loss of lock or of the input clock
      LOCK_HELD:
        if (!pll_locked_i || !input_clk_present_i)
          next_st.lock_state = LOCK_IDLE; // RQ8
      default: next_st.lock_state = LOCK_IDLE;
    endcase
    // ==========================================================
    // derived controls
    // cfg_o is registered so every output leaves a flop, at the cost
    // of one cycle after the register or status change
    idx = st.dev_cfg_two[RATIO_IDX_LSB +: 2];
    // auto switching, when on, overrides the source bit
    dynamic = auto_switch_en_i ? auto_dynamic_i
      : st.dev_cfg_two[FRAC_SRC_BIT]; // RQ14
    // indexed ratio rebuilt every cycle, msb byte first
    ratio_word = {st.ratio[{idx, 2'h0}], st.ratio[{idx, 2'h1}],
      st.ratio[{idx, 2'h2}], st.ratio[{idx, 2'h3}]}; // RQ15
    next_st.cfg.ratio_value = ratio_word;
    next_st.cfg.dynamic_mode = dynamic;
    case (st.func_one[REF_DIV_LSB +: 2])
      REF_DIV_BY4: next_st.cfg.ref_div_factor = DIV_FACTOR_4; // RQ1
      REF_DIV_BY2: next_st.cfg.ref_div_factor = DIV_FACTOR_2; // RQ1
      REF_DIV_BY1: next_st.cfg.ref_div_factor = DIV_FACTOR_1; // RQ1
      default: next_st.cfg.ref_div_factor = DIV_FACTOR_4;
    endcase
    // reserved code flagged, divider held at the safest ratio
    next_st.cfg.ref_div_bad =
      (st.func_one[REF_DIV_LSB +: 2] == REF_DIV_RSVD); // RQ1
    if (dynamic && !st.func_two[LF_FORMAT_BIT])
      next_st.cfg.ratio_frac_bits = FRAC_BITS_HIGH_MULT; // RQ5
    else
      next_st.cfg.ratio_frac_bits = FRAC_BITS_HIGH_RES; // RQ5 RQ6
    // gate low while unlocked unless the always-on bit is set
    next_st.cfg.clk_out_gate = st.func_two[UNLOCK_OE_BIT] ||
      pll_locked_i; // RQ3 RQ4
    next_st.cfg.active_min_bw = st.active_bw; // RQ7
  end

  // ==========================================================
  // state register
  // reset branch assigns constants only
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.lock_state <= LOCK_IDLE;
      st.func_one <= FUNC_CFG_ONE_RST;
      st.func_two <= FUNC_CFG_TWO_RST;
      st.func_three <= FUNC_CFG_THREE_RST;
      st.dev_cfg_two <= DEV_CFG_TWO_RST;
      st.global_cfg <= GLOBAL_CFG_RST;
      st.active_bw <= MIN_BW_RST;
      st.cfg.ref_div_factor <= DIV_FACTOR_4;
      st.cfg.ratio_frac_bits <= FRAC_BITS_HIGH_RES;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs, straight from the state flops
  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign cfg_o = st.cfg;

endmodule : prfc_config_bank

// ==== logic/prfc_pkg.sv ====
/*
  constants and carriers for the ratio and function configuration bank.
  assumes a byte-wide register port driven by the control port decoder.
*/
package prfc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] RATIO_BASE_ADDR = 8'h06;
  localparam logic [7:0] RATIO_LAST_ADDR = 8'h15;
  localparam logic [7:0] DEV_CFG_TWO_ADDR = 8'h04;
  localparam logic [7:0] GLOBAL_CFG_ADDR = 8'h05;
  localparam logic [7:0] FUNC_CFG_ONE_ADDR = 8'h16;
  localparam logic [7:0] FUNC_CFG_TWO_ADDR = 8'h17;
  localparam logic [7:0] FUNC_CFG_THREE_ADDR = 8'h1e;

  // ==========================================================
  // field positions
  localparam int FRAC_SRC_BIT = 0;
  localparam int RATIO_IDX_LSB = 1;
  localparam int DEV_CFG_EN_BIT = 0;
  localparam int REF_DIV_LSB = 3;
  localparam int UNLOCK_OE_BIT = 4;
  localparam int LF_FORMAT_BIT = 3;
  localparam int MIN_BW_LSB = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0] FUNC_CFG_ONE_RST = 8'h00;
  localparam logic [7:0] FUNC_CFG_TWO_RST = 8'h00;
  localparam logic [7:0] FUNC_CFG_THREE_RST = 8'h00;
  localparam logic [7:0] DEV_CFG_TWO_RST = 8'h00;
  localparam logic [7:0] GLOBAL_CFG_RST = 8'h00;
  localparam logic [2:0] MIN_BW_RST = 3'h0;

  // ==========================================================
  // encodings
  localparam logic [1:0] REF_DIV_BY4 = 2'h0;
  localparam logic [1:0] REF_DIV_BY2 = 2'h1;
  localparam logic [1:0] REF_DIV_BY1 = 2'h2;
  localparam logic [1:0] REF_DIV_RSVD = 2'h3;
  localparam logic [2:0] DIV_FACTOR_4 = 3'h4;
  localparam logic [2:0] DIV_FACTOR_2 = 3'h2;
  localparam logic [2:0] DIV_FACTOR_1 = 3'h1;
  localparam logic [4:0] FRAC_BITS_HIGH_MULT = 5'hc;
  localparam logic [4:0] FRAC_BITS_HIGH_RES = 5'h14;

  typedef enum logic [2:0] {
    LOCK_IDLE = 3'b001,
    LOCK_ACQUIRE = 3'b010,
    LOCK_HELD = 3'b100
  } prfc_lock_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prfc_reg_req_s;

  typedef struct packed {
    logic [2:0] ref_div_factor;
    logic ref_div_bad;
    logic clk_out_gate;
    logic [4:0] ratio_frac_bits;
    logic [2:0] active_min_bw;
    logic dynamic_mode;
    logic [31:0] ratio_value;
  } prfc_cfg_s;

endpackage : prfc_pkg
